// ### design/pkt_filter_pkg.sv
// Package: filter table constants, register map and carrier types
package pkt_filter_pkg;

    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int NUM_FILTERS    = 8;
    localparam int IDX_W          = 3;
    localparam int PORT_W         = 5;
    localparam logic [PORT_W-1:0] PORT_DEFAULT = 5'h01;
    localparam logic [PORT_W-1:0] GROUP_BASE   = 5'h19;
    localparam int CNT_W          = 16;

    // ------------------------------------------------------------------
    // Register map: address = {entry index, word select}
    // ------------------------------------------------------------------
    localparam int ADDR_W         = 8;
    localparam logic [3:0] W_CTRL      = 4'h0;
    localparam logic [3:0] W_SRC_LO    = 4'h1;
    localparam logic [3:0] W_SRC_HI    = 4'h2;
    localparam logic [3:0] W_SRC_MASK  = 4'h3;
    localparam logic [3:0] W_DST_LO    = 4'h4;
    localparam logic [3:0] W_DST_HI    = 4'h5;
    localparam logic [3:0] W_DST_MASK  = 4'h6;
    localparam logic [3:0] W_FVAL      = 4'h7;
    localparam logic [3:0] W_FMASK     = 4'h8;
    localparam logic [3:0] W_COUNT     = 4'h9;
    localparam logic [3:0] W_FOFFSET   = 4'ha;
    localparam logic [3:0] W_SRC_HI_EX = 4'hb;
    localparam logic [3:0] W_DST_HI_EX = 4'hc;
    localparam logic [3:0] W_MASK_EX   = 4'hd;
    localparam logic [ADDR_W-1:0] A_NEXT_INDEX = 8'hf0;

    // Control word fields; C_PTYPE places the type field in the W_FOFFSET word
    localparam int C_VALID   = 0;
    localparam int C_EXIT    = 1;
    localparam int C_PSEUDO  = 2;
    localparam int C_OR      = 3;
    localparam int C_PORT    = 4;
    localparam int C_GRPCMP  = 9;
    localparam int C_GRPNUM  = 11;
    localparam int C_SRCCMP  = 16;
    localparam int C_DSTCMP  = 18;
    localparam int C_PROCMP  = 20;
    localparam int C_FLDCMP  = 22;
    localparam int C_ORIGIN  = 24;
    localparam int C_PTYPE   = 16;

    localparam logic [47:0] MASK_ONES = 48'hffff_ffff_ffff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        compare_ignored = 2'b00,
        compare_match   = 2'b01,
        compare_inverse = 2'b10
    } cmp_mode_t;

    typedef enum logic [1:0] {
        origin_type = 2'b00,
        origin_ip   = 2'b01,
        origin_mac  = 2'b10,
        origin_sr   = 2'b11
    } origin_t;

    typedef struct packed {
        logic              valid;
        logic              exit_dir;
        logic              pseudo;
        logic              link_or;
        logic [PORT_W-1:0] port;
        cmp_mode_t         grp_cmp;
        logic [PORT_W-1:0] grp_num;
        cmp_mode_t         src_cmp;
        cmp_mode_t         dst_cmp;
        cmp_mode_t         pro_cmp;
        cmp_mode_t         fld_cmp;
        origin_t           origin;
        logic [15:0]       ptype;
        logic [15:0]       offset;
        logic [47:0]       src_lo;
        logic [47:0]       src_hi;
        logic [47:0]       src_mask;
        logic [47:0]       dst_lo;
        logic [47:0]       dst_hi;
        logic [47:0]       dst_mask;
        logic [63:0]       fval;
        logic [63:0]       fmask;
    } filter_entry_t;

    // Header summary of one packet, presented by the port datapath
    typedef struct packed {
        logic              exit_dir;
        logic [PORT_W-1:0] port;
        logic [PORT_W-1:0] in_port;
        logic [PORT_W-1:0] in_group;
        logic [47:0]       src_mac;
        logic [47:0]       dst_mac;
        logic [15:0]       eth_type;
        logic [63:0]       fld_type;
        logic [63:0]       fld_ip;
        logic [63:0]       fld_mac;
        logic [63:0]       fld_sr;
    } pkt_hdr_t;

endpackage : pkt_filter_pkg

// ### design/port_packet_filter_table.sv
// Port packet filter table with register port and verdict pipeline
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Each filter is entry or exit direction
// - Unconfigured comparison fields are left out
// - Match drops on hit, inverse on miss
// - Ignored comparison skips the field
// - Port/group compare used only on exit
// - Exit compares entry port/group with number
// - Numbers 25 and up are group identifiers
// - Pseudo filters count hits, never block
// - Indexed table, new filter takes next index
// - One sequential pass in index order
// - And/Or links next same-port same-direction entry
// - Masked source inside range, inverse outside
// - Source mask 48 bits, defaults all ones
// - Destination inside range, inverse outside
// - Separate destination mask, defaults all ones
// - Ethernet type compared against configured type
// - Masked custom field compared with value
// - Port defaults to port one
// - Low four octets ANDed with mask, compared; upper four always masked out
// - Field offset origin type, ip, mac, sr
module port_packet_filter_table
    import pkt_filter_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire logic              pkt_valid,
    input  wire pkt_hdr_t          pkt_hdr,
    output logic                   verdict_valid,
    output logic                   verdict_drop,
    output logic                   verdict_exit
);

    // ------------------------------------------------------------------
    // Filter table storage
    // ------------------------------------------------------------------
    filter_entry_t           tbl_reg [NUM_FILTERS];
    logic [CNT_W-1:0]        cnt_reg [NUM_FILTERS];
    logic [IDX_W:0]          next_index_reg;
    logic [IDX_W-1:0]        wr_idx;
    logic [3:0]              wr_word;
    logic                    sel_entry;

    assign wr_idx    = reg_addr[IDX_W+3:4];
    assign wr_word   = reg_addr[3:0];
    assign sel_entry = (reg_addr[ADDR_W-1:IDX_W+4] == '0);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                tbl_reg[i]          <= '0;
                tbl_reg[i].port     <= PORT_DEFAULT;
                tbl_reg[i].src_mask <= MASK_ONES;
                tbl_reg[i].dst_mask <= MASK_ONES;
            end
        end else if (reg_wr && sel_entry) begin
            case (wr_word)
                W_CTRL: begin
                    tbl_reg[wr_idx].valid    <= reg_wdata[C_VALID];
                    tbl_reg[wr_idx].exit_dir <= reg_wdata[C_EXIT];
                    tbl_reg[wr_idx].pseudo   <= reg_wdata[C_PSEUDO];
                    tbl_reg[wr_idx].link_or  <= reg_wdata[C_OR];
                    tbl_reg[wr_idx].port     <= reg_wdata[C_PORT +: PORT_W];
                    tbl_reg[wr_idx].grp_cmp  <= cmp_mode_t'(reg_wdata[C_GRPCMP +: 2]);
                    tbl_reg[wr_idx].grp_num  <= reg_wdata[C_GRPNUM +: PORT_W];
                    tbl_reg[wr_idx].src_cmp  <= cmp_mode_t'(reg_wdata[C_SRCCMP +: 2]);
                    tbl_reg[wr_idx].dst_cmp  <= cmp_mode_t'(reg_wdata[C_DSTCMP +: 2]);
                    tbl_reg[wr_idx].pro_cmp  <= cmp_mode_t'(reg_wdata[C_PROCMP +: 2]);
                    tbl_reg[wr_idx].fld_cmp  <= cmp_mode_t'(reg_wdata[C_FLDCMP +: 2]);
                    tbl_reg[wr_idx].origin   <= origin_t'(reg_wdata[C_ORIGIN +: 2]);
                end
                W_SRC_LO:    tbl_reg[wr_idx].src_lo[31:0]    <= reg_wdata;
                W_SRC_HI:    tbl_reg[wr_idx].src_hi[31:0]    <= reg_wdata;
                W_SRC_MASK:  tbl_reg[wr_idx].src_mask[31:0]  <= reg_wdata;
                W_DST_LO:    tbl_reg[wr_idx].dst_lo[31:0]    <= reg_wdata;
                W_DST_HI:    tbl_reg[wr_idx].dst_hi[31:0]    <= reg_wdata;
                W_DST_MASK:  tbl_reg[wr_idx].dst_mask[31:0]  <= reg_wdata;
                W_FVAL:      tbl_reg[wr_idx].fval[31:0]      <= reg_wdata;
                W_FMASK:     tbl_reg[wr_idx].fmask[31:0]     <= reg_wdata;
                W_FOFFSET: begin
                    tbl_reg[wr_idx].offset <= reg_wdata[15:0];
                    tbl_reg[wr_idx].ptype  <= reg_wdata[C_PTYPE +: 16];
                end
                W_SRC_HI_EX: begin
                    tbl_reg[wr_idx].src_lo[47:32] <= reg_wdata[15:0];
                    tbl_reg[wr_idx].src_hi[47:32] <= reg_wdata[31:16];
                end
                W_DST_HI_EX: begin
                    tbl_reg[wr_idx].dst_lo[47:32] <= reg_wdata[15:0];
                    tbl_reg[wr_idx].dst_hi[47:32] <= reg_wdata[31:16];
                end
                W_MASK_EX: begin
                    tbl_reg[wr_idx].src_mask[47:32] <= reg_wdata[15:0];
                    tbl_reg[wr_idx].dst_mask[47:32] <= reg_wdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Next free index: a control write with valid set to the slot at
    // the current index adds a filter and moves the index on
    // ------------------------------------------------------------------
    logic add_filter;
    assign add_filter = reg_wr && sel_entry && (wr_word == W_CTRL) && reg_wdata[C_VALID]
                        && ({1'b0, wr_idx} == next_index_reg)
                        && (next_index_reg < (IDX_W+1)'(NUM_FILTERS));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            next_index_reg <= '0;
        end else if (reg_wr && (reg_addr == A_NEXT_INDEX)) begin
            next_index_reg <= reg_wdata[IDX_W:0];
        end else if (add_filter) begin
            next_index_reg <= next_index_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Per-entry hit evaluation (combinational)
    // ------------------------------------------------------------------
    function automatic logic apply_cmp(input cmp_mode_t m, input logic hit);
        case (m)
            compare_match:   apply_cmp = hit;
            compare_inverse: apply_cmp = !hit;
            default:         apply_cmp = 1'b1;
        endcase
    endfunction : apply_cmp

    logic [NUM_FILTERS-1:0] applies;
    logic [NUM_FILTERS-1:0] crit;

    always_comb begin
        logic [47:0] sm;
        logic [47:0] dm;
        logic [63:0] fld;
        logic        in_hit;
        logic        grp_id;
        sm      = '0;
        dm      = '0;
        fld     = '0;
        in_hit  = 1'b0;
        grp_id  = 1'b0;
        applies = '0;
        crit    = '0;
        for (int i = 0; i < NUM_FILTERS; i++) begin
            sm = pkt_hdr.src_mac & tbl_reg[i].src_mask;
            dm = pkt_hdr.dst_mac & tbl_reg[i].dst_mask;
            case (tbl_reg[i].origin)
                origin_ip:  fld = pkt_hdr.fld_ip;
                origin_mac: fld = pkt_hdr.fld_mac;
                origin_sr:  fld = pkt_hdr.fld_sr;
                default:    fld = pkt_hdr.fld_type;
            endcase
            grp_id = (tbl_reg[i].grp_num >= GROUP_BASE);
            in_hit = grp_id ? (pkt_hdr.in_group == tbl_reg[i].grp_num)
                            : (pkt_hdr.in_port  == tbl_reg[i].grp_num);
            applies[i] = tbl_reg[i].valid && (tbl_reg[i].port == pkt_hdr.port)
                         && (tbl_reg[i].exit_dir == pkt_hdr.exit_dir);
            crit[i] = (!tbl_reg[i].exit_dir
                        || apply_cmp(tbl_reg[i].grp_cmp, in_hit))
                    && apply_cmp(tbl_reg[i].src_cmp,
                        (sm >= tbl_reg[i].src_lo) && (sm <= tbl_reg[i].src_hi))
                    && apply_cmp(tbl_reg[i].dst_cmp,
                        (dm >= tbl_reg[i].dst_lo) && (dm <= tbl_reg[i].dst_hi))
                    && apply_cmp(tbl_reg[i].pro_cmp,
                        pkt_hdr.eth_type == tbl_reg[i].ptype)
                    && apply_cmp(tbl_reg[i].fld_cmp,
                        (fld & tbl_reg[i].fmask) == tbl_reg[i].fval);
        end
    end

    // ------------------------------------------------------------------
    // One pass chain: each applicable non-pseudo entry links to the previous one
    // of the same port and direction by that entry's operator
    // ------------------------------------------------------------------
    logic drop_comb;
    logic [NUM_FILTERS-1:0] pseudo_hit;

    always_comb begin
        logic acc;
        logic seen;
        logic prev_or;
        acc        = 1'b0;
        seen       = 1'b0;
        prev_or    = 1'b0;
        pseudo_hit = '0;
        for (int i = 0; i < NUM_FILTERS; i++) begin
            if (applies[i]) begin
                if (tbl_reg[i].pseudo) begin
                    pseudo_hit[i] = crit[i];
                end else begin
                    if (!seen)
                        acc = crit[i];
                    else if (prev_or)
                        acc = acc || crit[i];
                    else
                        acc = acc && crit[i];
                    seen    = 1'b1;
                    prev_or = tbl_reg[i].link_or;
                end
            end
        end
        drop_comb  = seen && acc;
    end

    // ------------------------------------------------------------------
    // Verdict register, one cycle after the header
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            verdict_valid <= 1'b0;
            verdict_drop  <= 1'b0;
            verdict_exit  <= 1'b0;
        end else begin
            verdict_valid <= pkt_valid;
            verdict_drop  <= pkt_valid && drop_comb;
            verdict_exit  <= pkt_hdr.exit_dir;
        end
    end

    // ------------------------------------------------------------------
    // Pseudo statistics counters, write to clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_FILTERS; i++)
                cnt_reg[i] <= '0;
        end else begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                if (pkt_valid && pseudo_hit[i])
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
                else if (reg_wr && sel_entry && wr_word == W_COUNT
                         && wr_idx == IDX_W'(i))
                    cnt_reg[i] <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == A_NEXT_INDEX) begin
            reg_rdata <= {{(31-IDX_W){1'b0}}, next_index_reg};
        end else if (sel_entry) begin
            case (wr_word)
                W_CTRL: reg_rdata <= {6'h00, tbl_reg[wr_idx].origin,
                                      tbl_reg[wr_idx].fld_cmp, tbl_reg[wr_idx].pro_cmp,
                                      tbl_reg[wr_idx].dst_cmp, tbl_reg[wr_idx].src_cmp,
                                      tbl_reg[wr_idx].grp_num, tbl_reg[wr_idx].grp_cmp,
                                      tbl_reg[wr_idx].port, tbl_reg[wr_idx].link_or,
                                      tbl_reg[wr_idx].pseudo, tbl_reg[wr_idx].exit_dir,
                                      tbl_reg[wr_idx].valid};
                W_SRC_LO:    reg_rdata <= tbl_reg[wr_idx].src_lo[31:0];
                W_SRC_HI:    reg_rdata <= tbl_reg[wr_idx].src_hi[31:0];
                W_SRC_MASK:  reg_rdata <= tbl_reg[wr_idx].src_mask[31:0];
                W_DST_LO:    reg_rdata <= tbl_reg[wr_idx].dst_lo[31:0];
                W_DST_HI:    reg_rdata <= tbl_reg[wr_idx].dst_hi[31:0];
                W_DST_MASK:  reg_rdata <= tbl_reg[wr_idx].dst_mask[31:0];
                W_FVAL:      reg_rdata <= tbl_reg[wr_idx].fval[31:0];
                W_FMASK:     reg_rdata <= tbl_reg[wr_idx].fmask[31:0];
                W_COUNT:     reg_rdata <= {16'h0000, cnt_reg[wr_idx]};
                W_FOFFSET:   reg_rdata <= {tbl_reg[wr_idx].ptype, tbl_reg[wr_idx].offset};
                W_SRC_HI_EX: reg_rdata <= {tbl_reg[wr_idx].src_hi[47:32],
                                           tbl_reg[wr_idx].src_lo[47:32]};
                W_DST_HI_EX: reg_rdata <= {tbl_reg[wr_idx].dst_hi[47:32],
                                           tbl_reg[wr_idx].dst_lo[47:32]};
                W_MASK_EX:   reg_rdata <= {tbl_reg[wr_idx].dst_mask[47:32],
                                           tbl_reg[wr_idx].src_mask[47:32]};
                default:     reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence pkt_in_s;
        pkt_valid;
    endsequence

    verdict_follows_a: assert property (@(posedge clk) disable iff (!resetn)
        pkt_in_s |=> verdict_valid && (verdict_drop == $past(drop_comb)))
        else $error("verdict does not follow header");

    no_drop_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        !verdict_valid |-> !verdict_drop)
        else $error("drop without verdict");

    index_step_a: assert property (@(posedge clk) disable iff (!resetn)
        add_filter && !(reg_addr == A_NEXT_INDEX) |=>
            next_index_reg == $past(next_index_reg) + 1'b1)
        else $error("index not advanced");

    pseudo_count_a: assert property (@(posedge clk) disable iff (!resetn)
        pkt_valid && pseudo_hit[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 1'b1)
        else $error("pseudo hit not counted");

    pseudo_nodrop_a: assert property (@(posedge clk) disable iff (!resetn)
        pkt_valid && (applies & ~pseudo_hit & crit) == '0 |=> !verdict_drop)
        else $error("drop without real hit");

    mask_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> tbl_reg[0].src_mask == MASK_ONES && tbl_reg[0].port == PORT_DEFAULT)
        else $error("reset defaults wrong");

    read_lat_a: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == A_NEXT_INDEX |=> reg_rdata[IDX_W:0] == $past(next_index_reg))
        else $error("index read wrong");

    ignore_all_a: assert property (@(posedge clk) disable iff (!resetn)
        tbl_reg[0].valid && !tbl_reg[0].exit_dir && tbl_reg[0].src_cmp == compare_ignored
        && tbl_reg[0].dst_cmp == compare_ignored && tbl_reg[0].pro_cmp == compare_ignored
        && tbl_reg[0].fld_cmp == compare_ignored |-> crit[0])
        else $error("ignored fields blocked a hit");

    inverse_flip_a: assert property (@(posedge clk) disable iff (!resetn)
        tbl_reg[0].pro_cmp == compare_inverse && pkt_hdr.eth_type == tbl_reg[0].ptype
        |-> !crit[0])
        else $error("inverse protocol compare hit");

    count_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && sel_entry && wr_word == W_COUNT && wr_idx == '0
        && !(pkt_valid && pseudo_hit[0]) |=> cnt_reg[0] == '0)
        else $error("count not cleared");

endmodule : port_packet_filter_table

`default_nettype wire

// ### tb/port_path_model.sv
// Port datapath model: hands one packet header to the filter per request
`timescale 1ns/1ps
`default_nettype none
module port_path_model
    import pkt_filter_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     req,
    input  wire pkt_hdr_t hdr_in,
    output logic          pkt_valid,
    output pkt_hdr_t      pkt_hdr
);
    initial begin
        pkt_valid = 1'b0;
        pkt_hdr   = '0;
    end
    // Header stands one cycle, then is inverted each idle cycle, so the stale value returns every second cycle
    always @(posedge clk) begin
        pkt_valid <= req;
        pkt_hdr   <= req ? hdr_in : ~pkt_hdr;
    end
endmodule : port_path_model
`default_nettype wire

// ### tb/port_packet_filter_table_tb.sv
// Testbench for the port packet filter table
`timescale 1ns/1ps
`default_nettype none
module port_packet_filter_table_tb;
    import pkt_filter_pkg::*;
    logic        clk, resetn, reg_wr, reg_rd, req, e;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        pkt_valid, verdict_valid, verdict_drop, verdict_exit;
    logic [1:0]  sm, pm;
    pkt_hdr_t    pkt_hdr, h, hd;
    int          seed, bad_count, compares, cycles, i;

    port_packet_filter_table u_port_packet_filter_table (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr),
        .verdict_valid(verdict_valid), .verdict_drop(verdict_drop), .verdict_exit(verdict_exit));
    port_path_model u_port_path_model (.clk(clk), .req(req), .hdr_in(hd),
        .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] ad(input logic [2:0] x, input logic [3:0] w);
        return {1'b0, x, w};
    endfunction : ad
    function automatic logic [31:0] cw(input logic [3:0] f, input logic [4:0] p,
        input logic [1:0] g, input logic [4:0] n, input logic [1:0] s, input logic [1:0] q);
        return 32'(f) | (32'(p) << C_PORT) | (32'(g) << C_GRPCMP) | (32'(n) << C_GRPNUM)
            | (32'(s) << C_SRCCMP) | (32'(q) << C_PROCMP);
    endfunction : cw
    function automatic logic hit(input logic [1:0] m, input logic c);
        return (m == 2'd1) ? c : (m == 2'd2) ? !c : 1'b1;
    endfunction : hit

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic send(input logic x);
        @(posedge clk);
        req <= 1'b1;
        hd  <= h;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        check("verdict valid", verdict_valid, 32'h0000_0001);
        check("verdict drop", verdict_drop, 32'(x));
        check("verdict dir", verdict_exit, 32'(h.exit_dir));
    endtask : send
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 43; clk = 0; resetn = 0; reg_addr = '0; reg_wdata = '0;
        reg_wr = 0; reg_rd = 0; req = 0; h = '0; hd = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(ad(0, W_CTRL), d); check("ctrl reset", d, 32'h0000_0010);
        rd(ad(0, W_SRC_MASK), d); check("src mask", d, 32'hffff_ffff);
        rd(ad(0, W_MASK_EX), d); check("mask ex", d, 32'hffff_ffff);
        rd(8'hf1, d); check("unmapped", d, 32'h0000_0000);
        wr(ad(0, W_SRC_LO), 32'h0000_0100);
        wr(ad(0, W_SRC_HI), 32'h0000_01ff);
        wr(ad(0, W_SRC_HI_EX), 32'h0000_0000);
        wr(ad(0, W_FOFFSET), 32'h0806_0000);
        wr(ad(0, W_CTRL), cw(4'h1, 5'd2, 2'd0, 5'd0, 2'd1, 2'd0));
        rd(A_NEXT_INDEX, d); check("next index", d, 32'h0000_0001);
        for (i = 0; i < 40; i++) begin
            sm = ($random(seed) & 1) ? 2'd2 : 2'd1;
            pm = 2'($unsigned($random(seed)) % 3);
            wr(ad(0, W_CTRL), cw(4'h1, 5'd2, 2'd0, 5'd0, sm, pm));
            h = '0;
            h.exit_dir = 1'($random(seed));
            h.port = ($random(seed) & 1) ? 5'd2 : 5'd1;
            h.eth_type = ($random(seed) & 1) ? 16'h0806 : 16'h0800;
            case (i)
                0: h.src_mac = 48'h0000_0000_00ff;
                1: h.src_mac = 48'h0000_0000_0100;
                2: h.src_mac = 48'h0000_0000_01ff;
                3: h.src_mac = 48'h0000_0000_0200;
                default: h.src_mac = 48'($unsigned($random(seed)) % 'h300);
            endcase
            e = !h.exit_dir && h.port == 5'd2 && hit(sm, h.src_mac >= 'h100 && h.src_mac <= 'h1ff)
                && hit(pm, h.eth_type == 16'h0806);
            send(e);
        end
        // Entry 1 on another port sits between two chained port 2 entries
        wr(ad(1, W_CTRL), cw(4'h1, 5'd5, 2'd0, 5'd0, 2'd1, 2'd0));
        wr(ad(2, W_FOFFSET), 32'h0806_0000);
        wr(ad(2, W_CTRL), cw(4'h1, 5'd2, 2'd0, 5'd0, 2'd0, 2'd1));
        h = '0; h.port = 5'd2; h.src_mac = 48'h0000_0000_0150; h.eth_type = 16'h0800;
        for (i = 0; i < 2; i++) begin
            wr(ad(0, W_CTRL), cw(4'h1 | 4'(i << C_OR), 5'd2, 2'd0, 5'd0, 2'd1, 2'd0));
            send(i[0]);
        end
        wr(ad(0, W_CTRL), cw(4'h5, 5'd2, 2'd0, 5'd0, 2'd1, 2'd0));
        wr(ad(0, W_COUNT), 32'h0000_0000);
        send(1'b0);
        send(1'b0);
        rd(ad(0, W_COUNT), d); check("pseudo count", d, 32'h0000_0002);
        wr(ad(0, W_CTRL), cw(4'h9, 5'd2, 2'd1, 5'd9, 2'd1, 2'd0));
        h.in_port = 5'd4;
        send(1'b1);
        wr(ad(0, W_CTRL), cw(4'hb, 5'd3, 2'd1, 5'd25, 2'd0, 2'd0));
        h.exit_dir = 1'b1; h.port = 5'd3; h.in_port = 5'd25; h.in_group = 5'd25;
        send(1'b1);
        h.in_group = 5'd26;
        send(1'b0);
        // Entry 3: masked destination range and a field window after the IP header
        wr(ad(3, W_DST_LO), 32'h0000_0010);
        wr(ad(3, W_DST_HI), 32'h0000_001f);
        wr(ad(3, W_DST_MASK), 32'h0000_00ff);
        wr(ad(3, W_MASK_EX), 32'h0000_ffff);
        wr(ad(3, W_FVAL), 32'h0000_00ab);
        wr(ad(3, W_FMASK), 32'h0000_00ff);
        wr(ad(3, W_CTRL), 32'h0000_0061 | (32'h1 << C_DSTCMP) | (32'h1 << C_FLDCMP)
            | (32'h1 << C_ORIGIN));
        rd(A_NEXT_INDEX, d); check("next index add", d, 32'h0000_0004);
        h = '0; h.port = 5'd6; h.dst_mac = 48'h1234_5678_9a15;
        h.fld_ip = 64'hffff_ffff_ffff_ffab;
        send(1'b1);
        h.fld_ip[0] = 1'b0;
        send(1'b0);
        h.fld_ip[0] = 1'b1; h.dst_mac[7:0] = 8'h20;
        send(1'b0);
        wr(A_NEXT_INDEX, 32'h0000_0006);
        rd(A_NEXT_INDEX, d); check("index set", d, 32'h0000_0006);
        report_and_stop();
    end
endmodule : port_packet_filter_table_tb
`default_nettype wire
